// ---- hdl/cca_pkg.sv ----
/*
 counter array package: register map, field positions, timebase codes
 and the capture/compare mode decoder. assumes a 32-bit word bus.
*/
`default_nettype none
package cca_pkg;
	localparam int NUM_MODULES = 5;    // capture/compare modules
	localparam int CNT_W = 16;         // counter and module value width
	localparam int BYTE_W = 8;         // byte of counter or value
	localparam int MM_W = 7;           // module mode register width
	localparam int PRE_W = 4;          // prescaler width
	localparam int DIV12 = 12;         // slow system clock divider
	localparam int DIV4 = 4;           // fast system clock divider
	localparam int WORD_STEP = 4;      // bytes per register
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [BYTE_W-1:0] LOW_MAX = 8'hff;
	// timebase select codes
	localparam logic [1:0] TB_DIV12 = 2'h0;
	localparam logic [1:0] TB_DIV4 = 2'h1;
	localparam logic [1:0] TB_T0 = 2'h2;
	localparam logic [1:0] TB_EXT = 2'h3;
	// register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_MODE = 6'h04;
	localparam logic [5:0] OFS_COUNT = 6'h08;
	localparam logic [5:0] OFS_IRQEN = 6'h0c;
	localparam logic [5:0] OFS_STATUS = 6'h10;
	localparam logic [5:0] OFS_MMODE = 6'h14;
	localparam logic [5:0] OFS_MVAL = 6'h28;
	// field positions
	localparam int CTRL_OVF = 7;
	localparam int CTRL_RUN = 6;
	localparam int MODE_SEL = 1;
	localparam int MODE_OVF_IE = 0;
	localparam int IRQ_GLOBAL = 0;
	localparam int IRQ_GROUP = 1;
	localparam int MM_CMP = 6;
	localparam int MM_RISE = 5;
	localparam int MM_FALL = 4;
	localparam int MM_MATCH = 3;
	localparam int MM_TOG = 2;
	localparam int MM_PWM = 1;
	localparam int MM_IE = 0;

	typedef enum {CC_IDLE, CC_CAPTURE, CC_SWTIMER, CC_HSO, CC_PWM} cc_mode_t;

	// mode bits to operating mode; interrupt enable never matters
	function automatic cc_mode_t decode_mode(input logic [MM_W-1:0] m);
		cc_mode_t md;
		md = CC_IDLE;
		// R5: capture edges
		if (!m[MM_MATCH] && !m[MM_TOG] && !m[MM_PWM] && (m[MM_RISE] || m[MM_FALL]))
			md = CC_CAPTURE;
		// R7: pulse width, match ignored
		else if (m[MM_CMP] && m[MM_PWM] && !m[MM_RISE] && !m[MM_FALL] && !m[MM_TOG])
			md = CC_PWM;
		// R6: software timer or toggle
		else if (m[MM_CMP] && m[MM_MATCH] && !m[MM_RISE] && !m[MM_FALL] && !m[MM_PWM])
			md = m[MM_TOG] ? CC_HSO : CC_SWTIMER;
		return md;
	endfunction
endpackage
`default_nettype wire

// ---- hdl/cc_link_if.sv ----
/*
 link between the array core and one capture/compare unit.
 assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface cc_link_if;
	import cca_pkg::*;
	logic [CNT_W-1:0] count;   // shared counter value
	logic cnt_new;             // counter advanced last edge
	logic low_wrap;            // low byte wrapped last edge
	logic [MM_W-1:0] mode;     // module mode bits
	logic wr_en;               // software value write pulse
	logic [CNT_W-1:0] wr_data; // software value
	logic rise;                // qualified rising edge on the line
	logic fall;                // qualified falling edge on the line
	logic [CNT_W-1:0] value;   // module value
	logic event_p;             // capture or match pulse
	logic level;               // driven line level
	modport core (output count, cnt_new, low_wrap, mode, wr_en, wr_data, rise, fall,
		input value, event_p, level);
	modport unit (input count, cnt_new, low_wrap, mode, wr_en, wr_data, rise, fall,
		output value, event_p, level);
endinterface
`default_nettype wire

// ---- hdl/edge_sync.sv ----
/*
 two-stage synchroniser with edge pulses per bit.
 assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;  // first stage, read only by s2
		logic [W-1:0] s2;  // settled stage
		logic [W-1:0] s3;  // previous settled value
	} sync_t;
	sync_t st_ff, nxt_st;

	// shift chain
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = din;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// one pulse per settled edge
	assign rise = st_ff.s2 & ~st_ff.s3;
	assign fall = ~st_ff.s2 & st_ff.s3;
endmodule
`default_nettype wire

// ---- hdl/cc_unit.sv ----
/*
 one capture/compare unit: value register, mode actions, line level.
 assumes the core hands it qualified edges and counter step pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module cc_unit
	import cca_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	cc_link_if.unit lnk
);
	typedef struct packed {
		logic [CNT_W-1:0] value; // capture/compare value
		logic level;             // output line level
	} unit_t;
	unit_t st_ff, nxt_st;
	cc_mode_t md;   // decoded mode
	logic ev;       // event this cycle
	logic hit;      // full compare match on a new count

	assign md = decode_mode(lnk.mode);
	assign hit = lnk.cnt_new && (lnk.count == st_ff.value);

	// R4: each unit acts alone
	always_comb
	begin
		nxt_st = st_ff;
		ev = 1'b0;
		if (lnk.wr_en)
			nxt_st.value = lnk.wr_data;
		case (md)
			CC_CAPTURE:
			begin
				// R10: copy counter on edge
				if ((lnk.rise && lnk.mode[MM_RISE]) || (lnk.fall && lnk.mode[MM_FALL]))
				begin
					nxt_st.value = lnk.count;
					ev = 1'b1;
				end
			end
			CC_SWTIMER:
			begin
				// R13: flag on equality
				if (hit)
					ev = 1'b1;
			end
			CC_HSO:
			begin
				// R17: invert line on match
				if (hit)
				begin
					ev = 1'b1;
					nxt_st.level = ~st_ff.level;
				end
			end
			CC_PWM:
			begin
				// R18: low on wrap, reload, high on match
				if (lnk.low_wrap)
				begin
					nxt_st.level = 1'b0;
					nxt_st.value[BYTE_W-1:0] = nxt_st.value[CNT_W-1:BYTE_W];
				end
				else if (lnk.cnt_new && lnk.count[BYTE_W-1:0] == st_ff.value[BYTE_W-1:0])
					nxt_st.level = 1'b1;
			end
			default:
				;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign lnk.value = st_ff.value;
	assign lnk.level = st_ff.level;
	assign lnk.event_p = ev;

	a_capture_value: assert property (@(posedge clk) disable iff (sys_rst) // R10
		(md == CC_CAPTURE && ev) |=> st_ff.value == $past(lnk.count))
		else $error("capture did not store the counter");
	a_hso_toggle: assert property (@(posedge clk) disable iff (sys_rst) // R17
		(md == CC_HSO && lnk.cnt_new && lnk.count == st_ff.value) |=> st_ff.level != $past(st_ff.level))
		else $error("high-speed output did not toggle");
	a_pwm_wrap: assert property (@(posedge clk) disable iff (sys_rst) // R18
		(md == CC_PWM && lnk.low_wrap && !lnk.wr_en)
		|=> !st_ff.level && st_ff.value[BYTE_W-1:0] == $past(st_ff.value[CNT_W-1:BYTE_W]))
		else $error("pulse width wrap wrong");
endmodule
`default_nettype wire

// ---- hdl/counter_array.sv ----
/*
 programmable counter array top: shared counter, timebase, flags,
 interrupt request and an avalon-mm slave with waitrequest.
 assumes synchronous pins and a master that holds its request.
*/
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
// Behaviour
// R1: one 16-bit counter, five modules
// R2: line reaches pin only if crossbar enabled
// R3: counter ticks from one of four timebases
// R4: each module works alone in four modes
// R5: capture edge chosen by rise/fall enables
// R6: compare plus match selects software timer
// R7: toggle gives fast output, pwm gives pulses
// R8: module enable gates its flag interrupt
// R9: global and group enables gate requests
// R10: capture copies counter into module value
// R11: capture sets flag, may request interrupt
// R12: flags stay set until software clears
// R13: software timer flags on counter equality
// R14: core uses registers only
// R15: select code 00 /12, 01 /4, 10 t0, 11 ext
// R16: counter wrap sets overflow flag
// R17: fast output inverts line on match
// R18: pwm high on match, low on wrap
// R19: pins pass two flip-flops before edges
// R20: hardware set beats software clear
`timescale 1ns/1ns
`default_nettype none
module counter_array
	import cca_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [5:0] av_address,
	input wire logic av_read,
	input wire logic av_write,
	input wire logic [31:0] av_writedata,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	input wire logic timer0_overflow,
	input wire logic external_count_input,
	input wire logic [NUM_MODULES-1:0] crossbar_enable,
	input wire logic [NUM_MODULES-1:0] module_io_in,
	output logic [NUM_MODULES-1:0] module_io_out,
	output logic [NUM_MODULES-1:0] module_io_oe_n,
	output logic irq
);
	typedef struct packed {
		logic [CNT_W-1:0] count;                  // shared counter
		logic [PRE_W-1:0] pre;                    // clock prescaler
		logic cnt_new;                            // counter advanced
		logic low_wrap;                           // low byte wrapped
		logic run;                                // counter run
		logic ovf_flag;                           // counter overflow flag
		logic [NUM_MODULES-1:0] flags;            // module event flags
		logic [1:0] tb_sel;                       // timebase select
		logic ovf_ie;                             // overflow irq enable
		logic glob_ie;                            // global irq enable
		logic grp_ie;                             // array group irq enable
		logic [NUM_MODULES-1:0][MM_W-1:0] mmode;  // module mode registers
		logic waitreq;                            // bus wait
		logic [31:0] rdata;                       // bus read data
		logic irq;                                // interrupt request
		logic [NUM_MODULES-1:0] io_out;           // line levels
		logic [NUM_MODULES-1:0] io_oe_n;          // line drive enables
	} core_t;
	core_t st_ff, nxt_st;

	logic req;                           // bus request present
	logic wr_take;                       // write takes effect now
	logic tick;                          // timebase pulse
	logic adv;                           // counter advances
	logic [PRE_W-1:0] pre_lim;           // prescaler last value
	logic [31:0] rd_word;                // read mux
	logic [NUM_MODULES-1:0] mval_wr;     // value write strobes
	logic [NUM_MODULES-1:0] ev_vec;      // unit events
	logic [NUM_MODULES-1:0] lvl_vec;     // unit line levels
	logic [NUM_MODULES-1:0] drive_vec;   // unit drives its line
	logic [NUM_MODULES-1:0] ie_vec;      // module irq enables
	logic [NUM_MODULES-1:0] edge_rise;   // synchronised rises
	logic [NUM_MODULES-1:0] edge_fall;   // synchronised falls
	logic ext_fall;                      // external count falling edge
	logic ext_fall_unused;               // rising count edge has no use
	logic [CNT_W-1:0] val_vec [NUM_MODULES];  // unit values
	cc_link_if lnk [NUM_MODULES] ();

	// R19: synchronise lines and count input
	edge_sync #(.W(NUM_MODULES + 1)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.din({external_count_input, module_io_in}),
		.rise({ext_fall_unused, edge_rise}),
		.fall({ext_fall, edge_fall})
	);

	// R1: five units on the shared counter
	for (genvar i = 0; i < NUM_MODULES; i++)
	begin : g_mod
		assign lnk[i].count = st_ff.count;
		assign lnk[i].cnt_new = st_ff.cnt_new;
		assign lnk[i].low_wrap = st_ff.low_wrap;
		assign lnk[i].mode = st_ff.mmode[i];
		assign lnk[i].wr_en = mval_wr[i];
		assign lnk[i].wr_data = av_writedata[CNT_W-1:0];
		// R2: edges count only through an enabled crossbar
		assign lnk[i].rise = edge_rise[i] & crossbar_enable[i];
		assign lnk[i].fall = edge_fall[i] & crossbar_enable[i];
		assign ev_vec[i] = lnk[i].event_p;
		assign lvl_vec[i] = lnk[i].level;
		assign val_vec[i] = lnk[i].value;
		assign ie_vec[i] = st_ff.mmode[i][MM_IE];
		assign drive_vec[i] = (decode_mode(st_ff.mmode[i]) == CC_HSO) ||
			(decode_mode(st_ff.mmode[i]) == CC_PWM);
		cc_unit u_unit (
			.clk(clk),
			.sys_rst(sys_rst),
			.lnk(lnk[i])
		);
	end

	// next state of the whole core
	always_comb
	begin
		nxt_st = st_ff;
		req = av_read | av_write;
		wr_take = av_write & ~st_ff.waitreq;
		mval_wr = '0;
		// R15: prescaler limit and timebase choice
		pre_lim = (st_ff.tb_sel == TB_DIV4) ? PRE_W'(DIV4 - 1) : PRE_W'(DIV12 - 1);
		nxt_st.pre = (st_ff.pre >= pre_lim) ? '0 : st_ff.pre + 1'b1;
		case (st_ff.tb_sel)
			TB_DIV12:
				tick = (st_ff.pre >= pre_lim);
			TB_DIV4:
				tick = (st_ff.pre >= pre_lim);
			TB_T0:
				tick = timer0_overflow;
			default:
				tick = ext_fall;
		endcase
		// R3: counter steps only while running
		adv = st_ff.run & tick;
		nxt_st.cnt_new = adv;
		nxt_st.low_wrap = adv && (st_ff.count[BYTE_W-1:0] == LOW_MAX);
		if (adv)
			nxt_st.count = st_ff.count + 1'b1;
		// read mux, unmapped words read zero
		rd_word = '0;
		case (av_address)
			OFS_CTRL:
			begin
				rd_word[CTRL_OVF] = st_ff.ovf_flag;
				rd_word[CTRL_RUN] = st_ff.run;
				rd_word[NUM_MODULES-1:0] = st_ff.flags;
			end
			OFS_MODE:
			begin
				rd_word[MODE_SEL +: 2] = st_ff.tb_sel;
				rd_word[MODE_OVF_IE] = st_ff.ovf_ie;
			end
			OFS_COUNT:
				rd_word[CNT_W-1:0] = st_ff.count;
			OFS_IRQEN:
			begin
				rd_word[IRQ_GLOBAL] = st_ff.glob_ie;
				rd_word[IRQ_GROUP] = st_ff.grp_ie;
			end
			OFS_STATUS:
				rd_word[NUM_MODULES:0] = {st_ff.io_out, st_ff.irq};
			default:
			begin
				for (int i = 0; i < NUM_MODULES; i++)
				begin
					if (av_address == OFS_MMODE + 6'(WORD_STEP * i))
						rd_word[MM_W-1:0] = st_ff.mmode[i];
					if (av_address == OFS_MVAL + 6'(WORD_STEP * i))
						rd_word[CNT_W-1:0] = val_vec[i];
				end
			end
		endcase
		// R14: one wait cycle then answer
		nxt_st.waitreq = ~(req & st_ff.waitreq);
		if (req && st_ff.waitreq)
			nxt_st.rdata = rd_word;
		// register writes at the taking edge
		if (wr_take)
		begin
			case (av_address)
				OFS_CTRL:
				begin
					nxt_st.ovf_flag = av_writedata[CTRL_OVF];
					nxt_st.run = av_writedata[CTRL_RUN];
					nxt_st.flags = av_writedata[NUM_MODULES-1:0];
				end
				OFS_MODE:
				begin
					nxt_st.tb_sel = av_writedata[MODE_SEL +: 2];
					nxt_st.ovf_ie = av_writedata[MODE_OVF_IE];
				end
				OFS_COUNT:
					nxt_st.count = av_writedata[CNT_W-1:0];
				OFS_IRQEN:
				begin
					nxt_st.glob_ie = av_writedata[IRQ_GLOBAL];
					nxt_st.grp_ie = av_writedata[IRQ_GROUP];
				end
				default:
				begin
					for (int i = 0; i < NUM_MODULES; i++)
					begin
						if (av_address == OFS_MMODE + 6'(WORD_STEP * i))
							nxt_st.mmode[i] = av_writedata[MM_W-1:0];
						if (av_address == OFS_MVAL + 6'(WORD_STEP * i))
							mval_wr[i] = 1'b1;
					end
				end
			endcase
		end
		// R20: hardware sets after software writes
		// R11: events set module flags
		// R12: nothing but software clears
		nxt_st.flags = nxt_st.flags | ev_vec;
		// R16: wrap sets overflow flag
		if (adv && st_ff.count == CNT_MAX)
			nxt_st.ovf_flag = 1'b1;
		// R8: per-module gating
		// R9: global and group gating
		nxt_st.irq = st_ff.glob_ie && st_ff.grp_ie &&
			((|(st_ff.flags & ie_vec)) || (st_ff.ovf_flag && st_ff.ovf_ie));
		// R2: drive only through an enabled crossbar
		nxt_st.io_out = lvl_vec;
		nxt_st.io_oe_n = ~(drive_vec & crossbar_enable);
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_ff <= '0;
			st_ff.waitreq <= 1'b1;
			st_ff.io_oe_n <= '1;
		end
		else
			st_ff <= nxt_st;
	end

	assign av_readdata = st_ff.rdata;
	assign av_waitrequest = st_ff.waitreq;
	assign module_io_out = st_ff.io_out;
	assign module_io_oe_n = st_ff.io_oe_n;
	assign irq = st_ff.irq;

	a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // R20
		(wr_take && av_address == OFS_CTRL && |ev_vec) |=> (st_ff.flags & $past(ev_vec)) == $past(ev_vec))
		else $error("event lost against a clear");
	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst) // R12
		!(wr_take && av_address == OFS_CTRL) |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
		else $error("flag cleared by hardware");
	a_overflow_flag: assert property (@(posedge clk) disable iff (sys_rst) // R16
		(adv && st_ff.count == CNT_MAX && !(wr_take && av_address == OFS_COUNT))
		|=> st_ff.ovf_flag && st_ff.count == '0)
		else $error("wrap did not set overflow");
	a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst) // R9
		!(st_ff.glob_ie && st_ff.grp_ie) |=> !st_ff.irq)
		else $error("request while disabled");
	a_irq_source: assert property (@(posedge clk) disable iff (sys_rst) // R8
		st_ff.irq |-> $past(|(st_ff.flags & ie_vec)) || ($past(st_ff.ovf_flag) && $past(st_ff.ovf_ie)))
		else $error("request without enabled flag");
	a_div4_spacing: assert property (@(posedge clk) disable iff (sys_rst) // R15
		(tick && st_ff.tb_sel == TB_DIV4) ##1 (st_ff.tb_sel == TB_DIV4)[*4]
		|-> tick && $past(tick, 1) == 1'b0 && $past(tick, 2) == 1'b0 && $past(tick, 3) == 1'b0)
		else $error("divide by four spacing wrong");
	a_run_hold: assert property (@(posedge clk) disable iff (sys_rst) // R3
		(!st_ff.run && !(wr_take && av_address == OFS_COUNT)) |=> $stable(st_ff.count))
		else $error("counter moved while stopped");
	a_bus_answer: assert property (@(posedge clk) disable iff (sys_rst) // R14
		(req && st_ff.waitreq) |=> !st_ff.waitreq ##1 st_ff.waitreq)
		else $error("bus answer not one cycle");
	a_event_flag: assert property (@(posedge clk) disable iff (sys_rst) // R11
		|ev_vec |=> (st_ff.flags & $past(ev_vec)) == $past(ev_vec))
		else $error("event did not set flag");
endmodule
`default_nettype wire

// ---- tb/cpu_model.sv ----
/*
 processor core stand-in: avalon-mm master with one blocking transfer task.
 assumes one clock and a slave that answers by lowering waitrequest.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_model
(
	input wire logic clk,
	output logic [5:0] av_address,
	output logic av_read,
	output logic av_write,
	output logic [31:0] av_writedata,
	input wire logic [31:0] av_readdata,
	input wire logic av_waitrequest
);
	int hangs = 0; // transfers never answered

	// idle bus from time zero
	initial
	begin
		av_address = 6'h00;
		av_read = 1'b0;
		av_write = 1'b0;
		av_writedata = 32'h0;
	end

	// registers only
	// request held until waitrequest seen low, then released
	task automatic xfer(input logic wr, input logic [5:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge clk);
		av_address <= adr;
		av_write <= wr;
		av_read <= !wr;
		av_writedata <= wd;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (av_waitrequest !== 1'b0 && n < 40);
		// no answer within the bound
		if (av_waitrequest !== 1'b0)
			hangs++;
		rdat = av_readdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 testbench for the counter array: register tasks, pin stimulus, checks.
 assumes cpu_model as bus master and the package register map.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import cca_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic timer0_overflow = 1'b0; // pulse every 3 cycles
	logic external_count_input = 1'b1; // falls every 8 cycles
	logic [4:0] crossbar_enable = 5'h1f;
	logic [4:0] module_io_in = 5'h00;
	logic [5:0] av_address;
	logic av_read;
	logic av_write;
	logic [31:0] av_writedata;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	logic [4:0] module_io_out;
	logic [4:0] module_io_oe_n;
	logic irq;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	int tb_div [4] = '{DIV12, DIV4, 3, 8};
	logic [6:0] cap_mode [3] = '{7'h20, 7'h10, 7'h30};
	logic [5:0] rst_ofs [6] = '{OFS_CTRL, OFS_MODE, OFS_COUNT, OFS_IRQEN, OFS_MMODE, OFS_MVAL};

	counter_array i_counter_array (.clk(clk), .sys_rst(sys_rst), .av_address(av_address),
		.av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
		.av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
		.timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
		.crossbar_enable(crossbar_enable), .module_io_in(module_io_in),
		.module_io_out(module_io_out), .module_io_oe_n(module_io_oe_n), .irq(irq));
	cpu_model i_cpu_model (.clk(clk), .av_address(av_address), .av_read(av_read),
		.av_write(av_write), .av_writedata(av_writedata), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest));

	// 100 ns clock
	always #50 clk = ~clk;

	// timer 0 and external count sources
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		timer0_overflow <= (cyc % 3 == 0);
		if (cyc % 4 == 0)
			external_count_input <= ~external_count_input;
	end

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		i_cpu_model.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		i_cpu_model.xfer(1'b0, a, 32'h0, q);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// exact value compare
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// range compare for counts with phase slack
	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			fails++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		rd(a, q);
		chk(nm, exp, q);
	endtask

	task automatic print_verdict();
		fails += i_cpu_model.hangs;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (90000) @(posedge clk);
		fails++;
		print_verdict();
	end

	initial
	begin
		logic [31:0] q;
		int hi;
		tick(8);
		chk("waitrequest in reset", 32'h1, {31'h0, av_waitrequest});
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rchk("reset value", rst_ofs[i], 32'h0);
		wr(6'h3c, 32'hffffffff);
		rchk("unmapped", 6'h3c, 32'h0);
		wr(OFS_MODE, 32'hff);
		rchk("mode width", OFS_MODE, 32'h7);
		wr(OFS_COUNT, 32'h12345);
		rchk("count width", OFS_COUNT, 32'h2345);
		// every timebase code over 94 cycles
		for (int s = 0; s < 4; s++)
		begin
			wr(OFS_COUNT, 32'h0);
			wr(OFS_MODE, 32'(s) << MODE_SEL);
			wr(OFS_CTRL, 32'h40);
			tick(92);
			wr(OFS_CTRL, 32'h0);
			rd(OFS_COUNT, q);
			chk_rng("timebase count", 94 / tb_div[s] - 2, 94 / tb_div[s] + 1, q);
		end
		// capture edges on modules 0..2 with a still counter
		for (int m = 0; m < 3; m++)
		begin
			wr(OFS_MMODE + 6'(WORD_STEP * m), {25'h0, cap_mode[m]});
			wr(OFS_COUNT, 32'h1100 + m);
			module_io_in[m] <= 1'b1;
			tick(8);
			rchk("capture rise", OFS_MVAL + 6'(WORD_STEP * m), cap_mode[m][MM_RISE] ? 32'h1100 + m : 32'h0);
			wr(OFS_COUNT, 32'h2200 + m);
			module_io_in[m] <= 1'b0;
			tick(8);
			rchk("capture fall", OFS_MVAL + 6'(WORD_STEP * m),
				cap_mode[m][MM_FALL] ? 32'h2200 + m : (cap_mode[m][MM_RISE] ? 32'h1100 + m : 32'h0));
		end
		rchk("capture flags", OFS_CTRL, 32'h07);
		// line not routed: edge ignored
		wr(OFS_MMODE + 6'(WORD_STEP * 3), 32'h20);
		crossbar_enable[3] <= 1'b0;
		module_io_in[3] <= 1'b1;
		tick(8);
		rchk("unrouted capture", OFS_CTRL, 32'h07);
		wr(OFS_CTRL, 32'h0);
		rchk("flags cleared", OFS_CTRL, 32'h0);
		// counter wrap and interrupt gating
		wr(OFS_COUNT, 32'hfff0);
		wr(OFS_MODE, 32'h3);
		wr(OFS_IRQEN, 32'h3);
		wr(OFS_CTRL, 32'h40);
		tick(100);
		rchk("overflow flag", OFS_CTRL, 32'hc0);
		chk("overflow irq", 32'h1, {31'h0, irq});
		tick(20);
		rchk("flag persists", OFS_CTRL, 32'hc0);
		wr(OFS_IRQEN, 32'h1);
		tick(3);
		chk("group disabled", 32'h0, {31'h0, irq});
		wr(OFS_IRQEN, 32'h3);
		tick(3);
		chk("group enabled", 32'h1, {31'h0, irq});
		wr(OFS_MODE, 32'h2);
		tick(3);
		chk("overflow ie off", 32'h0, {31'h0, irq});
		// software timer on module 4, match at 0x20
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MVAL + 6'(WORD_STEP * 4), 32'h20);
		wr(OFS_MMODE + 6'(WORD_STEP * 4), 32'h48);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CTRL, 32'h40);
		tick(40);
		rchk("before match", OFS_CTRL, 32'h40);
		tick(120);
		rchk("after match", OFS_CTRL, 32'h50);
		chk("module ie off", 32'h0, {31'h0, irq});
		wr(OFS_MMODE + 6'(WORD_STEP * 4), 32'h49);
		tick(3);
		chk("module ie on", 32'h1, {31'h0, irq});
		wr(OFS_MMODE + 6'(WORD_STEP * 4), 32'h0);
		// high-speed output on module 2, match at 0x10
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MVAL + 6'(WORD_STEP * 2), 32'h10);
		wr(OFS_MMODE + 6'(WORD_STEP * 2), 32'h4c);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CTRL, 32'h40);
		tick(3);
		chk("fast out drive", 32'h0, {31'h0, module_io_oe_n[2]});
		chk("fast out start", 32'h0, {31'h0, module_io_out[2]});
		tick(80);
		chk("fast out toggled", 32'h1, {31'h0, module_io_out[2]});
		rchk("status lines", OFS_STATUS, 32'h08);
		crossbar_enable[2] <= 1'b0;
		tick(3);
		chk("fast out unrouted", 32'h1, {31'h0, module_io_oe_n[2]});
		// pulse width on module 3, high from low byte 0xc0
		crossbar_enable[3] <= 1'b1;
		module_io_in[3] <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MVAL + 6'(WORD_STEP * 3), 32'hc0c0);
		wr(OFS_MMODE + 6'(WORD_STEP * 3), 32'h42);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CTRL, 32'h40);
		hi = 0;
		repeat (2048)
		begin
			@(posedge clk);
			if (module_io_out[3] === 1'b1)
				hi++;
		end
		chk_rng("pwm high cycles", 464, 560, 32'(hi));
		chk("pwm drive", 32'h0, {31'h0, module_io_oe_n[3]});
		print_verdict();
	end
endmodule
`default_nettype wire
